// >>> rtl/rtcb_bank.sv
`timescale 1ns/1ps
module rtcb_bank (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// register port from serial interface
	input wire logic [6:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_hit_o,
	// normal controls and statuses
	input wire logic regulator_switch_permit_i,
	input wire logic [2:0] normal_reg_en_i,
	input wire logic [4:0] ready_status_i,
	input wire logic cal_request_i,
	input wire logic [3:0] auto_cal_result_i,
	// probe controls
	output logic if_probe_low_supply_o,
	output logic [2:0] analog_probe_select_o,
	output logic digital_regulator_off_o,
	output logic [1:0] synth_test_cfg_o,
	output logic osc_core_test_enable_o,
	// regulators and readies
	output logic [2:0] regulator_enable_o,
	output logic [4:0] ready_effective_o,
	// block enables
	output logic osc_core_enable_o,
	output logic prescaler_enable_o,
	output logic phase_detector_enable_o,
	output logic synth_clock_enable_o,
	output logic receive_bandgap_enable_o,
	output logic receiver_enable_o,
	// filter calibration
	output logic filter_cal_start_o,
	output logic [1:0] filter_cal_reference_shift_o,
	output logic [3:0] filter_cal_result_o,
	// crystal oscillator
	output logic [2:0] crystal_offset_current_o,
	output logic crystal_offset_sink_o,
	output logic crystal_offset_enable_o,
	output logic crystal_kick_disable_o,
	output logic crystal_detector_disable_o,
	output logic crystal_bias_disable_o
);
	// ---------------------------------------------------------------
	// storage
	// ---------------------------------------------------------------
	logic [7:0] regs [rtcb_pkg::NUM_REGS];
	logic [rtcb_pkg::NUM_REGS-1:0] wsel;
	logic [2:0] idx;
	logic hit;

	always_comb begin
		idx = 3'h0;
		hit = 1'b1;
		unique case (reg_addr_i)
			rtcb_pkg::ADDR_PROBE: idx = rtcb_pkg::IDX_PROBE;
			rtcb_pkg::ADDR_REGOVR: idx = rtcb_pkg::IDX_REGOVR;
			rtcb_pkg::ADDR_BLKEN: idx = rtcb_pkg::IDX_BLKEN;
			rtcb_pkg::ADDR_FCAL: idx = rtcb_pkg::IDX_FCAL;
			rtcb_pkg::ADDR_XTAL: idx = rtcb_pkg::IDX_XTAL;
			default: hit = 1'b0;
		endcase
	end

	genvar g;
	generate
		for (g = 0; g < rtcb_pkg::NUM_REGS; g++) begin : g_reg
			assign wsel[g] = reg_wr_i && hit && (idx == 3'(g));
			// reset to zero; the manual cal value has no defined reset, zero chosen
			rtcb_reg8 u_reg (
				.clk_sys_i(clk_sys_i),
				.rst_n_i(rst_n_i),
				.wr_en_i(wsel[g]),
				.wr_data_i(reg_wdata_i),
				.mask_i((g == rtcb_pkg::IDX_BLKEN) ? rtcb_pkg::BLKEN_MASK : rtcb_pkg::FULL_MASK),
				.q_o(regs[g])
			);
		end
	endgenerate

	logic [7:0] prb, ovr, blk, fc, xt;
	assign prb = regs[rtcb_pkg::IDX_PROBE];
	assign ovr = regs[rtcb_pkg::IDX_REGOVR];
	assign blk = regs[rtcb_pkg::IDX_BLKEN];
	assign fc = regs[rtcb_pkg::IDX_FCAL];
	assign xt = regs[rtcb_pkg::IDX_XTAL];

	// ---------------------------------------------------------------
	// output state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [7:0] rdata;
		logic hit;
		logic [7:0] probe;
		logic [2:0] reg_en;
		logic [4:0] rdy;
		logic [5:0] blk_en;
		logic cal_start;
		logic [1:0] shift;
		logic [3:0] cal_res;
		logic [7:0] xtal;
	} rtcb_out_s;
	rtcb_out_s st_r;
	rtcb_out_s st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.hit = reg_rd_i && hit;
		if (reg_rd_i && hit) begin
			st_nxt.rdata = regs[idx];
		end
		st_nxt.probe = prb;
		// permit high hands regulators fully to the test bits
		if (regulator_switch_permit_i) begin
			st_nxt.reg_en = ovr[rtcb_pkg::OVR_EN_HI:rtcb_pkg::OVR_EN_LO];
		end else begin
			st_nxt.reg_en = ovr[rtcb_pkg::OVR_EN_HI:rtcb_pkg::OVR_EN_LO] | normal_reg_en_i;
		end
		st_nxt.rdy = ovr[rtcb_pkg::OVR_RDY_HI:rtcb_pkg::OVR_RDY_LO] | ready_status_i;
		st_nxt.blk_en = {blk[rtcb_pkg::BLK_UP_HI:rtcb_pkg::BLK_UP_LO],
			blk[rtcb_pkg::BLK_DN_HI:rtcb_pkg::BLK_DN_LO]};
		// launch only when not suppressed
		st_nxt.cal_start = (fc[rtcb_pkg::FC_LAUNCH] | cal_request_i) & ~fc[rtcb_pkg::FC_SUPPRESS];
		st_nxt.shift = fc[rtcb_pkg::FC_SHIFT_HI:rtcb_pkg::FC_SHIFT_LO];
		// manual value used while auto calibration is suppressed
		st_nxt.cal_res = fc[rtcb_pkg::FC_SUPPRESS] ?
			fc[rtcb_pkg::FC_MAN_HI:rtcb_pkg::FC_MAN_LO] : auto_cal_result_i;
		st_nxt.xtal = xt;
		// sink direction meaningless without offset enable
		st_nxt.xtal[rtcb_pkg::XT_SINK] = xt[rtcb_pkg::XT_SINK] & xt[rtcb_pkg::XT_OFFEN];
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata_o = st_r.rdata;
	assign reg_hit_o = st_r.hit;
	assign if_probe_low_supply_o = st_r.probe[rtcb_pkg::PRB_LOWSUP];
	assign analog_probe_select_o = st_r.probe[rtcb_pkg::PRB_SEL_HI:rtcb_pkg::PRB_SEL_LO];
	assign digital_regulator_off_o = st_r.probe[rtcb_pkg::PRB_DIGOFF];
	assign synth_test_cfg_o = st_r.probe[rtcb_pkg::PRB_SYN_HI:rtcb_pkg::PRB_SYN_LO];
	assign osc_core_test_enable_o = st_r.probe[rtcb_pkg::PRB_OSCTST];
	assign regulator_enable_o = st_r.reg_en;
	assign ready_effective_o = st_r.rdy;
	assign osc_core_enable_o = st_r.blk_en[5];
	assign prescaler_enable_o = st_r.blk_en[4];
	assign phase_detector_enable_o = st_r.blk_en[3];
	assign synth_clock_enable_o = st_r.blk_en[2];
	assign receive_bandgap_enable_o = st_r.blk_en[1];
	assign receiver_enable_o = st_r.blk_en[0];
	assign filter_cal_start_o = st_r.cal_start;
	assign filter_cal_reference_shift_o = st_r.shift;
	assign filter_cal_result_o = st_r.cal_res;
	assign crystal_offset_current_o = st_r.xtal[rtcb_pkg::XT_OFFS_HI:rtcb_pkg::XT_OFFS_LO];
	assign crystal_offset_sink_o = st_r.xtal[rtcb_pkg::XT_SINK];
	assign crystal_offset_enable_o = st_r.xtal[rtcb_pkg::XT_OFFEN];
	assign crystal_kick_disable_o = st_r.xtal[rtcb_pkg::XT_KICKDIS];
	assign crystal_detector_disable_o = st_r.xtal[rtcb_pkg::XT_DETDIS];
	assign crystal_bias_disable_o = st_r.xtal[rtcb_pkg::XT_BIASDIS];

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	chk_readback_value: assert property (
		reg_wr_i && reg_addr_i == rtcb_pkg::ADDR_XTAL ##1 reg_rd_i && !reg_wr_i
		&& reg_addr_i == rtcb_pkg::ADDR_XTAL |=> reg_rdata_o == $past(reg_wdata_i, 2))
		else $error("readback mismatch");
	chk_reserved_zero: assert property (
		reg_hit_o && $past(reg_addr_i) == rtcb_pkg::ADDR_BLKEN |->
		(reg_rdata_o & ~rtcb_pkg::BLKEN_MASK) == 8'h00) else $error("reserved bits not zero");
	chk_reg_replace: assert property (
		regulator_switch_permit_i |=>
		regulator_enable_o == $past(ovr[rtcb_pkg::OVR_EN_HI:rtcb_pkg::OVR_EN_LO]))
		else $error("regulator replace wrong");
	chk_reg_or: assert property (
		!regulator_switch_permit_i |=> regulator_enable_o ==
		($past(ovr[rtcb_pkg::OVR_EN_HI:rtcb_pkg::OVR_EN_LO]) | $past(normal_reg_en_i)))
		else $error("regulator or wrong");
	chk_ready_force: assert property (
		ovr[rtcb_pkg::OVR_RDY_LO] |=> ready_effective_o[rtcb_pkg::OVR_RDY_LO])
		else $error("ready override lost");
	chk_cal_suppress: assert property (
		fc[rtcb_pkg::FC_SUPPRESS] |=> !filter_cal_start_o) else $error("cal not suppressed");
	chk_sink_gate: assert property (
		!xt[rtcb_pkg::XT_OFFEN] |=> !crystal_offset_sink_o)
		else $error("sink active without enable");
	chk_probe_sel: assert property (
		reg_wr_i && reg_addr_i == rtcb_pkg::ADDR_PROBE ##2 1'b1 |->
		analog_probe_select_o == $past(reg_wdata_i[rtcb_pkg::PRB_SEL_HI:rtcb_pkg::PRB_SEL_LO], 2))
		else $error("probe select wrong");
	chk_manual_cal: assert property (
		fc[rtcb_pkg::FC_SUPPRESS] |=>
		filter_cal_result_o == $past(fc[rtcb_pkg::FC_MAN_HI:rtcb_pkg::FC_MAN_LO]))
		else $error("manual cal wrong");
	chk_unmapped: assert property (
		reg_rd_i && !hit |=> !reg_hit_o) else $error("unmapped hit");
	cov_write_xtal: cover property (reg_wr_i && reg_addr_i == rtcb_pkg::ADDR_XTAL);
	cov_permit: cover property (regulator_switch_permit_i && ovr[rtcb_pkg::OVR_EN_HI]);
	cov_cal: cover property (filter_cal_start_o);
endmodule

// >>> shared/rtcb_pkg.sv
package rtcb_pkg;
	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [6:0] ADDR_PROBE = 7'h36;
	localparam logic [6:0] ADDR_REGOVR = 7'h37;
	localparam logic [6:0] ADDR_BLKEN = 7'h38;
	localparam logic [6:0] ADDR_FCAL = 7'h39;
	localparam logic [6:0] ADDR_XTAL = 7'h3a;
	localparam int NUM_REGS = 5;
	localparam logic [2:0] IDX_PROBE = 3'h0;
	localparam logic [2:0] IDX_REGOVR = 3'h1;
	localparam logic [2:0] IDX_BLKEN = 3'h2;
	localparam logic [2:0] IDX_FCAL = 3'h3;
	localparam logic [2:0] IDX_XTAL = 3'h4;
	// ---------------------------------------------------------------
	// reset values and masks
	// ---------------------------------------------------------------
	localparam logic [7:0] RESET_VAL = 8'h00;
	localparam logic [7:0] BLKEN_MASK = 8'hf6;
	localparam logic [7:0] FULL_MASK = 8'hff;
	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int PRB_LOWSUP = 7;
	localparam int PRB_SEL_HI = 6;
	localparam int PRB_SEL_LO = 4;
	localparam int PRB_DIGOFF = 3;
	localparam int PRB_SYN_HI = 2;
	localparam int PRB_SYN_LO = 1;
	localparam int PRB_OSCTST = 0;
	localparam int OVR_EN_HI = 7;
	localparam int OVR_EN_LO = 5;
	localparam int OVR_RDY_HI = 4;
	localparam int OVR_RDY_LO = 0;
	localparam int BLK_UP_HI = 7;
	localparam int BLK_UP_LO = 4;
	localparam int BLK_DN_HI = 2;
	localparam int BLK_DN_LO = 1;
	localparam int FC_LAUNCH = 7;
	localparam int FC_SUPPRESS = 6;
	localparam int FC_SHIFT_HI = 5;
	localparam int FC_SHIFT_LO = 4;
	localparam int FC_MAN_HI = 3;
	localparam int FC_MAN_LO = 0;
	localparam int XT_OFFS_HI = 7;
	localparam int XT_OFFS_LO = 5;
	localparam int XT_SINK = 4;
	localparam int XT_OFFEN = 3;
	localparam int XT_KICKDIS = 2;
	localparam int XT_DETDIS = 1;
	localparam int XT_BIASDIS = 0;
	// reference shift encodings
	localparam logic [1:0] SHIFT_NONE = 2'h0;
	localparam logic [1:0] SHIFT_P125 = 2'h1;
	localparam logic [1:0] SHIFT_M62 = 2'h2;
	localparam logic [1:0] SHIFT_M41 = 2'h3;
endpackage

// >>> rtl/rtcb_reg8.sv
`timescale 1ns/1ps
// one 8-bit storage register with write mask
module rtcb_reg8 (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// write side
	input wire logic wr_en_i,
	input wire logic [7:0] wr_data_i,
	input wire logic [7:0] mask_i,
	// stored value
	output logic [7:0] q_o
);
	typedef struct packed {
		logic [7:0] q;
	} rtcb_reg_s;
	rtcb_reg_s st_r;
	rtcb_reg_s st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (wr_en_i) begin
			st_nxt.q = wr_data_i & mask_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r <= '{q: rtcb_pkg::RESET_VAL};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q_o = st_r.q;
endmodule

// >>> verif/rtcb_host_model.sv
`timescale 1ns/1ps
// host on the register port; every change lands on the falling edge
module rtcb_host_model #(
	parameter bit LOW_SUPPLY = 1'b0
) (
	// clock
	input wire logic clk_sys_i,
	// register port
	output logic [6:0] reg_addr_o,
	output logic reg_wr_o,
	output logic [7:0] reg_wdata_o,
	output logic reg_rd_o
);
	// set only for a standard application, where crystal test bits stay quiet
	bit normal_mode = 1'b0;
	initial begin
		reg_addr_o = 7'h00;
		reg_wr_o = 1'b0;
		reg_wdata_o = 8'h00;
		reg_rd_o = 1'b0;
	end
	// caller must be at a falling edge; sent is what really went out
	task automatic wr_reg(input logic [6:0] a, input logic [7:0] d, output logic [7:0] sent);
		sent = d;
		if (LOW_SUPPLY && a == rtcb_pkg::ADDR_PROBE) sent[7] = 1'b1;
		if (normal_mode && a == rtcb_pkg::ADDR_XTAL) sent[3:1] = 3'h0;
		reg_addr_o = a;
		reg_wdata_o = sent;
		reg_wr_o = 1'b1;
		@(negedge clk_sys_i);
		reg_wr_o = 1'b0;
		// stale data must not look valid once the strobe is gone
		reg_wdata_o = ~sent;
	endtask
	task automatic rd_reg(input logic [6:0] a);
		reg_addr_o = a;
		reg_rd_o = 1'b1;
		@(negedge clk_sys_i);
		reg_rd_o = 1'b0;
	endtask
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic permit = 1'b0;
	logic [2:0] nen = 3'h0;
	logic [4:0] rdy = 5'h00;
	logic creq = 1'b0;
	logic [3:0] acal = 4'h0;
	logic [6:0] addr;
	logic wr;
	logic [7:0] wdata;
	logic rd;
	logic [7:0] rdata;
	logic hit;
	logic [36:0] outs;
	logic [7:0] m [5];
	logic [7:0] last;
	int fail_count = 0;
	int cmp_count = 0;
	always #12.5 clk_sys = ~clk_sys;
	// low supply host, so the probe flag path is exercised
	rtcb_host_model #(.LOW_SUPPLY(1'b1)) host_u (.clk_sys_i(clk_sys), .reg_addr_o(addr), .reg_wr_o(wr),
		.reg_wdata_o(wdata), .reg_rd_o(rd));
	rtcb_bank dut_u (.clk_sys_i(clk_sys), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wr_i(wr),
		.reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_hit_o(hit),
		.regulator_switch_permit_i(permit), .normal_reg_en_i(nen), .ready_status_i(rdy),
		.cal_request_i(creq), .auto_cal_result_i(acal),
		.if_probe_low_supply_o(outs[36]), .analog_probe_select_o(outs[35:33]),
		.digital_regulator_off_o(outs[32]), .synth_test_cfg_o(outs[31:30]),
		.osc_core_test_enable_o(outs[29]), .regulator_enable_o(outs[28:26]),
		.ready_effective_o(outs[25:21]), .osc_core_enable_o(outs[20]),
		.prescaler_enable_o(outs[19]), .phase_detector_enable_o(outs[18]),
		.synth_clock_enable_o(outs[17]), .receive_bandgap_enable_o(outs[16]),
		.receiver_enable_o(outs[15]), .filter_cal_start_o(outs[14]),
		.filter_cal_reference_shift_o(outs[13:12]), .filter_cal_result_o(outs[11:8]),
		.crystal_offset_current_o(outs[7:5]), .crystal_offset_sink_o(outs[4]),
		.crystal_offset_enable_o(outs[3]), .crystal_kick_disable_o(outs[2]),
		.crystal_detector_disable_o(outs[1]), .crystal_bias_disable_o(outs[0]));
	// -------------------------------
	// expectations and checks
	// -------------------------------
	function automatic logic [36:0] expect_outs();
		return {m[0], permit ? m[1][7:5] : m[1][7:5] | nen, m[1][4:0] | rdy,
			m[2][7:4], m[2][2:1], (m[3][7] | creq) & ~m[3][6], m[3][5:4],
			m[3][6] ? m[3][3:0] : acal, m[4][7:5], m[4][4] & m[4][3], m[4][3:0]};
	endfunction
	task automatic test_done();
		if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [36:0] got, input logic [36:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// write, read back on the very next edge, then look at the controls
	task automatic step(input logic [2:0] idx, input logic [7:0] d);
		logic [7:0] s;
		{permit, nen, rdy, creq, acal} = 14'($urandom);
		host_u.wr_reg(rtcb_pkg::ADDR_PROBE + 7'(idx), d, s);
		m[idx] = s & (idx == rtcb_pkg::IDX_BLKEN ? rtcb_pkg::BLKEN_MASK : rtcb_pkg::FULL_MASK);
		host_u.rd_reg(rtcb_pkg::ADDR_PROBE + 7'(idx));
		chk(37'(rdata), 37'(m[idx]));
		chk(37'(hit), 37'h1);
		chk(outs, expect_outs());
		chk(outs, expect_outs());
		chk(outs, expect_outs());
		last = m[idx];
	endtask
	initial begin
		repeat (100000) @(posedge clk_sys);
		fail_count++;
		test_done();
	end
	initial begin
		logic [7:0] s;
		void'($urandom(32'h3f12b1c3));
		m = '{default: 8'h00};
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys);
		rst_n = 1'b1;
		chk(outs, 37'h0);
		// unmapped writes next to the bank must leave it untouched
		host_u.wr_reg(7'h35, 8'hff, s);
		@(negedge clk_sys);
		host_u.wr_reg(7'h3b, 8'hff, s);
		for (int i = 0; i < rtcb_pkg::NUM_REGS; i++) begin
			host_u.rd_reg(rtcb_pkg::ADDR_PROBE + 7'(i));
			chk(37'(rdata), 37'h0);
			@(negedge clk_sys);
		end
		for (int k = 0; k < 4; k++) begin
			step(rtcb_pkg::IDX_FCAL, (8'($urandom) & 8'hcf) | 8'(k << 4));
		end
		repeat (75) step(3'($urandom_range(4)), 8'($urandom));
		// standard application: crystal test bits must stay quiet
		host_u.normal_mode = 1'b1;
		repeat (75) step(3'($urandom_range(4)), 8'($urandom));
		@(negedge clk_sys);
		host_u.rd_reg(7'h3b);
		chk(37'(rdata), 37'(last));
		chk(37'(hit), 37'h0);
		// second reset in mid-run
		rst_n = 1'b0;
		@(negedge clk_sys);
		chk(outs, 37'h0);
		rst_n = 1'b1;
		m = '{default: 8'h00};
		host_u.rd_reg(rtcb_pkg::ADDR_XTAL);
		chk(37'(rdata), 37'h0);
		test_done();
	end
endmodule
